/* shared/strap_pkg.sv */
// constants and carrier types for the reset-time strap capture block
// assumes a single 125 MHz clock domain and a synchronous reset
package strap_pkg;
   // ==========================================================
   // pin map
   localparam int NUM_PINS = 16;
   localparam int PROTO_PIN = 9;
   localparam int HOLD_HIGH_PIN = 8;
   localparam int SEL_DEF_LSB = 0;
   localparam int SEL_DEF_W = 4;
   localparam int SEL_MIN_W = 4;
   localparam int SEL_MAX_W = 16;
   // ==========================================================
   // reset values
   localparam logic [3:0] SEL_PULLUP_VAL = 4'hF;
   localparam logic [15:0] PINS_RST = 16'hFFFF;
   localparam logic ADDR_BIT_DEF = 1'b0;
   // ==========================================================
   // host port protocols
   typedef enum logic [0:0] {
      PROTO_SPI = 1'b0,
      PROTO_I2C = 1'b1
   } proto_t;

   // decisions handed to the rest of the device
   typedef struct packed {
      proto_t main_proto;
      proto_t aux_proto;
      logic main_addr_bit2;
      logic aux_addr_bit2;
      logic eeprom_skip;
      logic [SEL_MAX_W-1:0] stored_config_section;
      logic hold_pin_ok;
   } strap_cfg_t;
endpackage : strap_pkg

/* src/strap_capture.sv */
// reset-time pin strap capture and configuration decision logic
// assumes pins are synchronous to clk and master_reset_n is a sampled
// level; the factory info block provides the pin function masks
`timescale 1ns/10ps
// Contract
// R01 - capture all pins at master reset rise
// R02 - pin 9 low: main SPI, aux I2C
// R03 - board holds pin 8 high during reset
// R04 - address bit defaults zero unless pin assigned
// R05 - highest-index address pin wins
// R06 - address bit affects only I2C port
// R07 - high inhibit pin skips EEPROM read
// R08 - no inhibit pin: always search EEPROM
// R09 - inhibit is OR of assigned pins
// R10 - no select pins: use pins 3..0
// R11 - undriven default pins select config 15
// R12 - select word ordered lowest pin LSB
// R13 - fewer than four: upper bits zero
// R14 - more than four: wider select word
// R15 - functions from factory block; unprogrammed default
// R16 - captured values stay writable by host
// R17 - undriven function pins read high
// R18 - defaults: clocks off, pins general input
// R19 - test-access pins not used for straps
// R20 - select pins carry no other function
// R21 - bad checksum: skip load, keep defaults
// R22 - captured values held after reset
module strap_capture #(
   parameter int NUM_PINS = strap_pkg::NUM_PINS,
   parameter int SEL_W = strap_pkg::SEL_MAX_W,
   parameter int NUM_OUT_CLKS = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic master_reset_n,
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic [NUM_PINS-1:0] pin_driven,
   input wire logic info_programmed,
   input wire logic [NUM_PINS-1:0] addr_pin_mask,
   input wire logic [NUM_PINS-1:0] inhibit_pin_mask,
   input wire logic [NUM_PINS-1:0] select_pin_mask,
   input wire logic host_wr,
   input wire strap_pkg::strap_cfg_t host_wdata,
   input wire logic cfg_load_done,
   input wire logic cfg_checksum_ok,
   output strap_pkg::strap_cfg_t cfg,
   output logic captured,
   output logic cfg_load_apply,
   output logic [NUM_OUT_CLKS-1:0] out_clk_en,
   output logic [NUM_PINS-1:0] pin_gp_input
);
   // ==========================================================
   // pull-ups and reset edge
   logic [NUM_PINS-1:0] pin_lvl;
   logic mr_q_r;
   logic rise;
   logic [NUM_PINS-1:0] snap_r;
   logic captured_r;

   // undriven pins read high through the internal pull-up, one cell per pin
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pull
         assign pin_lvl[g] = pin_driven[g] ? pin_in[g] : 1'b1; // R17
      end
   endgenerate
   assign rise = master_reset_n & ~mr_q_r;

   // edge detector on the reset pin; starts at the released level so a pin
   // already high when srst drops is not taken for a fresh edge
   always_ff @(posedge clk) begin
      if (srst) begin
         mr_q_r <= 1'b1;
      end else begin
         mr_q_r <= master_reset_n;
      end
   end

   // snapshot is taken only on the rising edge and then frozen, so later
   // pin traffic (alarms, gp outputs) cannot disturb the decisions
   always_ff @(posedge clk) begin
      if (srst) begin
         snap_r <= strap_pkg::PINS_RST;
         captured_r <= 1'b0;
      end else if (rise) begin
         snap_r <= pin_lvl; // R01 R22
         captured_r <= 1'b1;
      end
   end
   assign captured = captured_r;

   // ==========================================================
   // function masks, unprogrammed parts fall back to defaults
   logic [NUM_PINS-1:0] addr_m;
   logic [NUM_PINS-1:0] inh_m;
   logic [NUM_PINS-1:0] sel_m;
   assign addr_m = info_programmed ? addr_pin_mask : '0; // R15
   assign inh_m = info_programmed ? inhibit_pin_mask : '0; // R15
   assign sel_m = info_programmed ? select_pin_mask : '0; // R15

   // ==========================================================
   // address bit: highest assigned index wins
   logic addr_bit;
   always_comb begin
      addr_bit = strap_pkg::ADDR_BIT_DEF; // R04
      for (int i = 0; i < NUM_PINS; i++) begin
         if (addr_m[i]) begin
            addr_bit = snap_r[i]; // R05
         end
      end
   end

   // eeprom inhibit is the or of every assigned pin, none means search
   logic inhibit;
   assign inhibit = |(inh_m & snap_r); // R07 R08 R09

   // ==========================================================
   // selection word: compact assigned pins into low bits by index
   logic [SEL_W-1:0] sel_packed;
   logic [SEL_W-1:0] sel_word;
   always_comb begin
      int k;
      k = 0;
      sel_packed = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (sel_m[i] && k < SEL_W) begin
            sel_packed[k] = snap_r[i]; // R12 R13 R14
            k = k + 1;
         end
      end
   end

   // default pins 3..0; with pull-ups this lands on config 15
   always_comb begin
      if (sel_m == '0) begin
         sel_word = '0;
         sel_word[strap_pkg::SEL_DEF_W-1:0] =
            snap_r[strap_pkg::SEL_DEF_LSB +: strap_pkg::SEL_DEF_W]; // R10 R11
      end else begin
         sel_word = sel_packed;
      end
   end

   // ==========================================================
   // decisions, set once from the snapshot, host may overwrite later
   strap_pkg::strap_cfg_t cfg_r;
   strap_pkg::strap_cfg_t cfg_nxt;
   logic decide_r;

   always_comb begin
      logic p9;
      p9 = snap_r[strap_pkg::PROTO_PIN];
      cfg_nxt = '0;
      cfg_nxt.main_proto = p9 ? strap_pkg::PROTO_I2C : strap_pkg::PROTO_SPI; // R02
      cfg_nxt.aux_proto = p9 ? strap_pkg::PROTO_SPI : strap_pkg::PROTO_I2C; // R02
      // the bit only reaches whichever port came up as i2c
      cfg_nxt.main_addr_bit2 = p9 ? addr_bit : 1'b0; // R06
      cfg_nxt.aux_addr_bit2 = p9 ? 1'b0 : addr_bit; // R06
      cfg_nxt.eeprom_skip = inhibit;
      cfg_nxt.stored_config_section = sel_word;
      // board must hold this pin high; reported, not enforced
      cfg_nxt.hold_pin_ok = snap_r[strap_pkg::HOLD_HIGH_PIN]; // R03
   end

   // one-cycle delay so decisions use the fresh snapshot
   always_ff @(posedge clk) begin
      if (srst) begin
         decide_r <= 1'b0;
      end else begin
         decide_r <= rise;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_r <= '0;
         cfg_r.aux_proto <= strap_pkg::PROTO_I2C;
         cfg_r.stored_config_section <= SEL_W'(strap_pkg::SEL_PULLUP_VAL);
         cfg_r.hold_pin_ok <= 1'b1;
      end else if (decide_r) begin
         cfg_r <= cfg_nxt;
      end else if (host_wr) begin
         cfg_r <= host_wdata; // R16
      end
   end
   assign cfg = cfg_r;

   // ==========================================================
   // neutral register defaults and load gating
   // a failed checksum never asserts apply, so defaults remain
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_load_apply <= 1'b0;
      end else begin
         cfg_load_apply <= cfg_load_done & cfg_checksum_ok & info_programmed; // R21
      end
   end

   // everything off and pins as inputs from srst on; no load or host write changes them
   always_ff @(posedge clk) begin
      if (srst) begin
         out_clk_en <= '0; // R18
         pin_gp_input <= '1; // R18
      end
   end

   // ==========================================================
   // reference terms for the checks, the low bit and count found by scanning the opposite way
   // so a slip in the compaction loop is not repeated here
   logic sel_low_bit;
   logic sel_top_bit;
   int sel_cnt;
   always_comb begin
      sel_low_bit = 1'b0;
      sel_top_bit = 1'b0;
      sel_cnt = 0;
      for (int i = NUM_PINS - 1; i >= 0; i--) begin
         if (sel_m[i]) begin
            sel_low_bit = snap_r[i];
            sel_cnt = sel_cnt + 1;
         end
      end
      for (int i = 0; i < NUM_PINS; i++) begin
         if (sel_m[i]) begin
            sel_top_bit = snap_r[i];
         end
      end
   end

   // ==========================================================
   // checks
   // snapshot moves only on a reset edge
   hold_snap_a: assert property (@(posedge clk) disable iff (srst) // R22
      !rise |=> $stable(snap_r)) else $error("snapshot changed without edge");
   // snapshot equals the pin levels at the edge
   capture_a: assert property (@(posedge clk) disable iff (srst) // R01
      rise |=> snap_r == $past(pin_lvl)) else $error("capture mismatch");
   // protocol pair follows pin 9
   proto_a: assert property (@(posedge clk) disable iff (srst) // R02
      decide_r |=> cfg.main_proto == strap_pkg::proto_t'($past(snap_r[9])) &&
      cfg.aux_proto != cfg.main_proto) else $error("protocol pick wrong");
   // the spi port never sees the address bit
   spi_addr_a: assert property (@(posedge clk) disable iff (srst) // R06
      decide_r |=> (cfg.main_proto == strap_pkg::PROTO_SPI) ?
      !cfg.main_addr_bit2 : !cfg.aux_addr_bit2) else $error("addr on spi port");
   // no assigned pin means a zero bit
   addr_def_a: assert property (@(posedge clk) disable iff (srst) // R04
      (addr_m == '0) |-> !addr_bit) else $error("addr bit not zero");
   // inhibit is the or of the assigned pins
   inhibit_or_a: assert property (@(posedge clk) disable iff (srst) // R09
      decide_r |=> cfg.eeprom_skip == |($past(inh_m) & $past(snap_r)))
      else $error("inhibit wrong");
   // default selection comes from pins 3..0
   sel_def_a: assert property (@(posedge clk) disable iff (srst) // R10
      decide_r && sel_m == '0 |=> cfg.stored_config_section == {12'h0000, $past(snap_r[3:0])})
      else $error("default select wrong");
   // a failed checksum never applies a load
   checksum_a: assert property (@(posedge clk) disable iff (srst) // R21
      !cfg_checksum_ok |=> !cfg_load_apply) else $error("bad load applied");
   // neutral defaults stay put
   outs_off_a: assert property (@(posedge clk) disable iff (srst) // R18
      out_clk_en == '0 && pin_gp_input == '1) else $error("defaults lost");
   // flag comes up right behind the edge
   captured_a: assert property (@(posedge clk) disable iff (srst) // R01
      rise |=> captured)
      else $error("capture flag missing");
   // decision strobe follows the edge by one cycle
   decide_a: assert property (@(posedge clk) disable iff (srst) // R01
      rise |=> decide_r)
      else $error("decision strobe missing");
   // once taken the flag never drops outside srst
   flag_stays_a: assert property (@(posedge clk) disable iff (srst) // R22
      captured |=> captured)
      else $error("capture flag dropped");
   // decisions hold between a capture and a host write
   cfg_hold_a: assert property (@(posedge clk) disable iff (srst) // R22
      !decide_r && !host_wr |=> $stable(cfg))
      else $error("decisions moved by themselves");
   // a host write lands when no capture competes
   host_take_a: assert property (@(posedge clk) disable iff (srst) // R16
      host_wr && !decide_r |=> cfg == $past(host_wdata))
      else $error("host write lost");
   // the top pin wins when it carries the address function
   addr_top_a: assert property (@(posedge clk) disable iff (srst) // R05
      decide_r && addr_m[NUM_PINS-1] |=>
      (cfg.main_addr_bit2 | cfg.aux_addr_bit2) == $past(snap_r[NUM_PINS-1]))
      else $error("address pin priority wrong");
   // both ports get a zero bit when nothing is assigned
   addr_none_a: assert property (@(posedge clk) disable iff (srst) // R04
      decide_r && addr_m == '0 |=> !cfg.main_addr_bit2 && !cfg.aux_addr_bit2)
      else $error("address bit set without pin");
   // no inhibit pin means the eeprom search goes ahead
   no_inhibit_a: assert property (@(posedge clk) disable iff (srst) // R08
      decide_r && inh_m == '0 |=> !cfg.eeprom_skip)
      else $error("search skipped without pin");
   // a high inhibit pin skips the search
   inhibit_hi_a: assert property (@(posedge clk) disable iff (srst) // R07
      decide_r && |(inh_m & snap_r) |=> cfg.eeprom_skip)
      else $error("search not skipped");
   // pulled-up default pins pick configuration 15
   sel15_a: assert property (@(posedge clk) disable iff (srst) // R11
      decide_r && sel_m == '0 && snap_r[3:0] == 4'hF |=>
      cfg.stored_config_section == SEL_W'(strap_pkg::SEL_PULLUP_VAL))
      else $error("pull-up select not 15");
   // lowest assigned pin is the lsb
   sel_lsb_a: assert property (@(posedge clk) disable iff (srst) // R12
      decide_r && sel_m != '0 |-> sel_word[0] == sel_low_bit)
      else $error("select lsb wrong");
   // highest assigned pin is the msb, however many there are
   sel_msb_a: assert property (@(posedge clk) disable iff (srst) // R14
      decide_r && sel_cnt > 0 && sel_cnt <= SEL_W |-> sel_word[sel_cnt - 1] == sel_top_bit)
      else $error("select msb wrong");
   // bits above the assigned pins stay zero
   sel_upper_a: assert property (@(posedge clk) disable iff (srst) // R13
      decide_r && sel_m != '0 && sel_cnt < SEL_W |-> (sel_word >> sel_cnt) == '0)
      else $error("select upper bits set");
   // unprogrammed parts ignore the inhibit and address masks
   unprog_a: assert property (@(posedge clk) disable iff (srst) // R15
      decide_r && !info_programmed |=>
      !cfg.eeprom_skip && !cfg.main_addr_bit2 && !cfg.aux_addr_bit2)
      else $error("masks used on unprogrammed part");
   // an undriven pin never reads low
   pull_up_a: assert property (@(posedge clk) disable iff (srst) // R17
      (~pin_driven & ~pin_lvl) == '0)
      else $error("undriven pin read low");
   // a good load is applied one cycle later
   apply_ok_a: assert property (@(posedge clk) disable iff (srst) // R21
      cfg_load_done && cfg_checksum_ok && info_programmed |=> cfg_load_apply)
      else $error("good load not applied");
   // the hold pin level is reported as captured
   hold_pin_a: assert property (@(posedge clk) disable iff (srst) // R03
      decide_r |=> cfg.hold_pin_ok == $past(snap_r[strap_pkg::HOLD_HIGH_PIN]))
      else $error("hold pin report wrong");
   // srst clears the flag and the apply pulse
   srst_clear_a: assert property (@(posedge clk) // R01
      srst |=> !captured && !cfg_load_apply)
      else $error("reset did not clear flags");

   rise_c: cover property (@(posedge clk) rise);
   host_c: cover property (@(posedge clk) host_wr && !decide_r);
   sel15_c: cover property (@(posedge clk) cfg.stored_config_section == 16'h000F);
   i2c_main_c: cover property (@(posedge clk) cfg.main_proto == strap_pkg::PROTO_I2C);
   skip_c: cover property (@(posedge clk) cfg.eeprom_skip);
endmodule : strap_capture

/* tb/strap_board.sv */
// board strapping model: pull-ups on every pin plus optional driving logic
// assumes the bench chooses which pins are driven and to what level
`timescale 1ns/10ps
// ==========================================================
// strapping model
module strap_board (
   input wire logic master_reset_n,
   input wire logic [15:0] lvl,
   input wire logic [15:0] drv,
   output logic [15:0] pin_in,
   output logic [15:0] pin_driven
);
   // an undriven pin floats up through its pull-up, never to an unknown
   always_comb begin
      pin_driven = drv;
      pin_in = (lvl & drv) | ~drv;
      if (!master_reset_n) begin
         pin_in[strap_pkg::HOLD_HIGH_PIN] = 1'b1;
         pin_driven[strap_pkg::HOLD_HIGH_PIN] = 1'b1;
      end
   end
endmodule : strap_board

/* tb/testbench.sv */
// self-checking bench for the reset-time strap capture block
// assumes the design defaults: 16 pins, 16-bit select word, 12 clocks
`timescale 1ns/10ps
module testbench;
   // ==========================================================
   // stimulus rows: masks and pin levels; pins 8 and test pins left alone
   typedef struct packed {
      logic prog;
      logic [15:0] a, i, s, lvl, drv;
   } row_t;
   row_t rows [6] = '{
      '{1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
      '{1'b1, 16'h00A0, 16'h0000, 16'h0000, 16'h0080, 16'h02A0},
      '{1'b1, 16'h0000, 16'h1400, 16'h0064, 16'h1024, 16'h1464},
      '{1'b1, 16'h0000, 16'h0800, 16'h30F0, 16'h2050, 16'h30F0},
      '{1'b0, 16'h0001, 16'hFFFF, 16'h00F0, 16'h0005, 16'h000F},
      '{1'b1, 16'h4000, 16'h0000, 16'h0000, 16'h0000, 16'h000F}};
   logic clk = 1'b0, srst = 1'b1, master_reset_n = 1'b0, host_wr = 1'b0;
   logic load_done = 1'b0, sum_ok = 1'b0, captured, apply;
   logic [15:0] pin_in, pin_driven, gp_in;
   logic [11:0] clk_en;
   row_t r = '0;
   strap_pkg::strap_cfg_t cfg, wdata = '0, e;
   int error_cnt = 0, n_checks = 0;
   strap_board board (.master_reset_n(master_reset_n), .lvl(r.lvl), .drv(r.drv),
      .pin_in(pin_in), .pin_driven(pin_driven));
   strap_capture DUT (.clk(clk), .srst(srst), .master_reset_n(master_reset_n),
      .pin_in(pin_in), .pin_driven(pin_driven), .info_programmed(r.prog),
      .addr_pin_mask(r.a), .inhibit_pin_mask(r.i), .select_pin_mask(r.s),
      .host_wr(host_wr), .host_wdata(wdata), .cfg_load_done(load_done),
      .cfg_checksum_ok(sum_ok), .cfg(cfg), .captured(captured), .cfg_load_apply(apply),
      .out_clk_en(clk_en), .pin_gp_input(gp_in));
   // 125 MHz clock
   initial begin
      forever #4 clk = ~clk;
   end
   // ==========================================================
   // expected decisions worked out from the pin rules
   function automatic strap_pkg::strap_cfg_t expect_cfg(row_t x);
      logic [15:0] p;
      logic ab;
      int k;
      strap_pkg::strap_cfg_t c;
      p = x.lvl | ~x.drv;
      ab = 1'b0;
      k = 0;
      c = '0;
      c.hold_pin_ok = 1'b1;
      c.main_proto = strap_pkg::proto_t'(p[9]);
      c.aux_proto = strap_pkg::proto_t'(~p[9]);
      for (int n = 0; n < 16; n++) begin
         if (x.prog && x.a[n]) ab = p[n]; // highest index written last
         if (x.prog && x.s[n]) begin
            c.stored_config_section[k] = p[n];
            k++;
         end
      end
      if (k == 0) c.stored_config_section = {12'h000, p[3:0]};
      c.main_addr_bit2 = p[9] & ab;
      c.aux_addr_bit2 = ~p[9] & ab;
      c.eeprom_skip = x.prog & (|(x.i & p));
      return c;
   endfunction : expect_cfg
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   // watchdog sized well beyond the roughly forty cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      close_out();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      e = '{strap_pkg::PROTO_SPI, strap_pkg::PROTO_I2C, 1'b0, 1'b0, 1'b0, 16'h000F, 1'b1};
      check("reset cfg", 32'(cfg), 32'(e));
      check("reset captured", 32'(captured), 32'h0000_0000);
      check("clock enables", 32'(clk_en), 32'h0000_0000);
      check("gp inputs", 32'(gp_in), 32'h0000_FFFF);
      foreach (rows[n]) begin
         r = rows[n];
         master_reset_n = 1'b0;
         @(negedge clk);
         master_reset_n = 1'b1;
         repeat (3) @(negedge clk);
         check("captured", 32'(captured), 32'h0000_0001);
         check("row cfg", 32'(cfg), 32'(expect_cfg(rows[n])));
      end
      // later pin activity must not move the decisions
      r.lvl = 16'hFFFF;
      r.drv = 16'hFFFF;
      repeat (4) @(negedge clk);
      check("held cfg", 32'(cfg), 32'(expect_cfg(rows[5])));
      // host overwrite of captured values
      wdata = '{strap_pkg::PROTO_I2C, strap_pkg::PROTO_SPI, 1'b1, 1'b0, 1'b1, 16'hA5C3, 1'b0};
      host_wr = 1'b1;
      @(negedge clk);
      host_wr = 1'b0;
      @(negedge clk);
      check("host write", 32'(cfg), 32'(wdata));
      // a load with bad checksum is not applied, a good one is
      for (int k = 0; k < 2; k++) begin
         sum_ok = k[0];
         load_done = 1'b1;
         @(negedge clk);
         load_done = 1'b0;
         check("apply", 32'(apply), 32'(k));
         @(negedge clk);
         check("apply pulse", 32'(apply), 32'h0000_0000);
      end
      close_out();
   end
endmodule : testbench
